/* File: ccr_checker.sv */
// Port assertions for the clock and reset sequencer.
// Assumes a bind from the testbench top file; one clock domain.
`timescale 1ns/1ps
module ccr_checker (
    input wire logic                 clk_in,
    input wire logic                 reset_n_in,
    input wire logic                 por_n_in,
    input wire logic                 system_reset_in,
    input wire logic                 pcie_port0_fund_reset_in,
    input wire logic                 pcie_port1_fund_reset_in,
    input wire ccr_pkg::ccr_ic_req_s ic_req_in,
    input wire ccr_pkg::ccr_ic_rsp_s ic_rsp_out,
    input wire logic                 pll_locked_out,
    input wire logic                 core_clock_out,
    input wire logic [7:0]           subblock_reset_out,
    input wire logic                 pcie_port0_fund_reset_buf,
    input wire logic                 pcie_port1_fund_reset_buf
);
    import ccr_pkg::*;
    // ****
    // Properties
    // ****
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    chk_fund_copy: assert property (
        pcie_port0_fund_reset_buf == pcie_port0_fund_reset_in
        && pcie_port1_fund_reset_buf == pcie_port1_fund_reset_in)
        else $error("fundamental reset copy wrong");
    // Registered outputs clear on the edge that sees the reset, so look one edge later.
    chk_por_quiet: assert property (!por_n_in |=>
        !core_clock_out && !pll_locked_out && subblock_reset_out == SUBBLOCK_RST_INIT)
        else $error("activity during power-on reset");
    chk_init_held: assert property ($rose(por_n_in) |->
        (subblock_reset_out == SUBBLOCK_RST_INIT && !pll_locked_out)[*8])
        else $error("sub-blocks not held after power-on");
    chk_lock_bound: assert property (
        $rose(por_n_in) |-> ##[20:40] pll_locked_out)
        else $error("lock not reached after power-on");
    chk_core_runs: assert property (
        pll_locked_out && $past(pll_locked_out) |-> core_clock_out != $past(core_clock_out))
        else $error("core clock stalled while locked");
    chk_refuse_sys: assert property (
        system_reset_in[*3] ##0 ic_req_in.valid |=>
        ic_rsp_out.refused && !ic_rsp_out.ack ##1 $stable(subblock_reset_out))
        else $error("request served during system reset");
    chk_write_lands: assert property (
        !system_reset_in[*3] ##0 (ic_req_in.valid && ic_req_in.write && pll_locked_out)
        |=> ic_rsp_out.ack ##1 subblock_reset_out == $past(ic_req_in.data, 2))
        else $error("sub-block write not applied");
    chk_read_back: assert property (
        !system_reset_in[*3] ##0 (ic_req_in.valid && !ic_req_in.write && pll_locked_out)
        |=> ic_rsp_out.ack && ic_rsp_out.data == subblock_reset_out)
        else $error("read data wrong");
endmodule

/* File: ccr_clock_reset.sv */
// Central clock and reset controller of the coherent subsystem.
// Assumes clk_in is free running; power-on, system and fundamental resets,
// and fabric coherent clocks arrive asynchronously from outside.
`timescale 1ns/1ps

module ccr_clock_reset #(
    parameter int unsigned CORE_DIV = ccr_pkg::CORE_DIV_DEFAULT
) (
    input  wire logic                  clk_in,
    input  wire logic                  reset_n_in,
    input  wire logic                  por_n_in,
    input  wire logic                  system_reset_in,
    input  wire ccr_pkg::ccr_ref_e     pll_ref_select_in,
    input  wire ccr_pkg::ccr_user_e    user_clock_setting_in,
    input  wire logic                  fabric_coherent_port0_clock,
    input  wire logic                  fabric_coherent_port1_clock,
    input  wire logic                  pcie_port0_fund_reset_in,
    input  wire logic                  pcie_port1_fund_reset_in,
    input  wire ccr_pkg::ccr_ic_req_s  ic_req_in,
    output ccr_pkg::ccr_ic_rsp_s       ic_rsp_out,
    output logic                       pll_locked_out,
    output ccr_pkg::ccr_ref_e          pll_ref_out,
    output logic                       core_clock_out,
    output logic                       core_div_clock_out,
    output logic                       pcie_port0_user_clock,
    output logic                       pcie_port1_user_clock,
    output logic [1:0]                 coherent_clock_seen_out,
    output logic [7:0]                 subblock_reset_out,
    output logic                       pcie_port0_fund_reset_buf,
    output logic                       pcie_port1_fund_reset_buf
);
    import ccr_pkg::*;

    // ************************************************************
    // Reset synchronisers
    // ************************************************************
    logic [1:0] por_sync;
    logic [1:0] sys_sync;
    logic       ctrl_reset;
    logic       sys_reset_active;

    // Power-on reset reaches only this controller; assert at once, release late.
    always_ff @(posedge clk_in or negedge por_n_in) begin
        if (!por_n_in) begin
            por_sync <= 2'h0;
        end else begin
            por_sync <= {por_sync[0], 1'b1};
        end
    end

    always_ff @(posedge clk_in or posedge system_reset_in) begin
        if (system_reset_in) begin
            sys_sync <= 2'h3;
        end else begin
            sys_sync <= {sys_sync[0], 1'b0};
        end
    end

    assign ctrl_reset       = !reset_n_in || !por_sync[1];
    assign sys_reset_active = sys_sync[1] || ctrl_reset;

    // ************************************************************
    // PLL sequencing
    // ************************************************************
    ccr_state_e  state;
    logic [15:0] lock_count;

    always_ff @(posedge clk_in) begin
        if (ctrl_reset) begin
            state      <= CCR_POR_HELD;
            lock_count <= 16'h0;
        end else begin
            unique case (state)
                CCR_POR_HELD: begin
                    state      <= CCR_PLL_LOCKING;
                    lock_count <= 16'h0;
                end
                CCR_PLL_LOCKING: begin
                    lock_count <= lock_count + 16'h1;
                    if (lock_count == 16'(PLL_LOCK_CYCLES - 1)) begin
                        state <= CCR_CLOCKS_RUN;
                    end
                end
                CCR_CLOCKS_RUN: begin
                    state <= CCR_CLOCKS_RUN;
                end
            endcase
        end
    end

    // The reference is caught while the PLL is parked, so it never swaps under lock.
    always_ff @(posedge clk_in) begin
        if (ctrl_reset) begin
            pll_ref_out <= CCR_REF_PLATFORM;
        end else if (state == CCR_POR_HELD) begin
            pll_ref_out <= pll_ref_select_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (ctrl_reset) begin
            pll_locked_out <= 1'b0;
        end else begin
            pll_locked_out <= (state == CCR_CLOCKS_RUN);
        end
    end

    // ************************************************************
    // Clock models
    // ************************************************************
    // The core and derived clocks are modelled as toggling levels at a scaled rate.
    logic [7:0] core_div_count;
    logic [7:0] user_div_count;
    logic [7:0] user_div;

    function automatic logic [7:0] user_divisor(input ccr_user_e setting);
        unique case (setting)
            CCR_USER_62M5: user_divisor = 8'h08;
            CCR_USER_125M: user_divisor = 8'h04;
            CCR_USER_250M: user_divisor = 8'h02;
            CCR_USER_500M: user_divisor = 8'h02;
        endcase
    endfunction

    assign user_div = user_divisor(user_clock_setting_in);

    always_ff @(posedge clk_in) begin
        if (ctrl_reset || state != CCR_CLOCKS_RUN) begin
            core_clock_out <= 1'b0;
        end else begin
            core_clock_out <= !core_clock_out;
        end
    end

    always_ff @(posedge clk_in) begin
        if (ctrl_reset || state != CCR_CLOCKS_RUN) begin
            core_div_count     <= 8'h0;
            core_div_clock_out <= 1'b0;
        end else if (core_div_count == 8'(CORE_DIV - 1)) begin
            core_div_count     <= 8'h0;
            core_div_clock_out <= !core_div_clock_out;
        end else begin
            core_div_count <= core_div_count + 8'h1;
        end
    end

    // Both user clocks share one setting; the 500 MHz code is held at 250 MHz.
    always_ff @(posedge clk_in) begin
        if (ctrl_reset || state != CCR_CLOCKS_RUN) begin
            user_div_count        <= 8'h0;
            pcie_port0_user_clock <= 1'b0;
            pcie_port1_user_clock <= 1'b0;
        end else if (user_div_count >= user_div - 8'h1) begin
            user_div_count        <= 8'h0;
            pcie_port0_user_clock <= !pcie_port0_user_clock;
            pcie_port1_user_clock <= !pcie_port1_user_clock;
        end else begin
            user_div_count <= user_div_count + 8'h1;
        end
    end

    // ************************************************************
    // Fabric coherent clock sampling
    // ************************************************************
    // Fabric clocks are unrelated to every internal clock, so each is only ever
    // seen through two flops and an edge is taken from the second and third.
    logic [1:0] coh_meta;
    logic [1:0] coh_sync;
    logic [1:0] coh_last;

    always_ff @(posedge clk_in) begin
        if (ctrl_reset) begin
            coh_meta <= 2'h0;
            coh_sync <= 2'h0;
            coh_last <= 2'h0;
        end else begin
            coh_meta <= {fabric_coherent_port1_clock, fabric_coherent_port0_clock};
            coh_sync <= coh_meta;
            coh_last <= coh_sync;
        end
    end

    always_ff @(posedge clk_in) begin
        if (ctrl_reset) begin
            coherent_clock_seen_out <= 2'h0;
        end else begin
            coherent_clock_seen_out <= coherent_clock_seen_out | (coh_sync ^ coh_last);
        end
    end

    // ************************************************************
    // Sub-block reset register on the internal interconnect
    // ************************************************************
    logic [7:0] subblock_reset;

    always_ff @(posedge clk_in) begin
        if (ctrl_reset) begin
            subblock_reset <= SUBBLOCK_RST_INIT;
        end else if (ic_req_in.valid && ic_req_in.write && !sys_reset_active) begin
            subblock_reset <= ic_req_in.data;
        end
    end

    always_ff @(posedge clk_in) begin
        if (ctrl_reset) begin
            ic_rsp_out <= '0;
        end else begin
            ic_rsp_out.ack     <= ic_req_in.valid && !sys_reset_active;
            ic_rsp_out.refused <= ic_req_in.valid && sys_reset_active;
            ic_rsp_out.data    <= (ic_req_in.valid && !sys_reset_active && !ic_req_in.write)
                                  ? subblock_reset : 8'h0;
        end
    end

    // Sub-blocks also stay in reset until the clocks they run on are alive.
    // Power-on reset reaches the sub-block resets at once, with no clock edge needed,
    // so a sub-block never runs on after the controller itself has been reset.
    always_ff @(posedge clk_in or negedge por_n_in) begin
        if (!por_n_in) begin
            subblock_reset_out <= SUBBLOCK_RST_INIT;
        end else if (ctrl_reset) begin
            subblock_reset_out <= SUBBLOCK_RST_INIT;
        end else begin
            subblock_reset_out <= subblock_reset
                                | {8{state != CCR_CLOCKS_RUN}};
        end
    end

    // ************************************************************
    // Fundamental resets
    // ************************************************************
    // A plain buffer: the reset must reach the PHY even with no clock running.
    assign pcie_port0_fund_reset_buf = pcie_port0_fund_reset_in;
    assign pcie_port1_fund_reset_buf = pcie_port1_fund_reset_in;

endmodule

/* File: ccr_fabric_model.sv */
// Fabric side model: two coherent-port PLL clocks.
// Assumes the bench enables it once the device is out of power-on reset.
`timescale 1ns/1ps
module ccr_fabric_model (
    input  wire logic run_in,
    output logic      coh0_clock_out,
    output logic      coh1_clock_out
);
    // ****
    // Clocks
    // ****
    // About 141 and 107 MHz; odd periods keep them clear of the 40 ns clock.
    // One process per clock, so each output has a single driver.
    initial begin
        coh0_clock_out = 1'b0;
        forever #3.55 coh0_clock_out = run_in ? !coh0_clock_out : 1'b0;
    end
    initial begin
        coh1_clock_out = 1'b0;
        forever #4.65 coh1_clock_out = run_in ? !coh1_clock_out : 1'b0;
    end
endmodule

/* File: ccr_pkg.sv */
// Constants and types of the coherent subsystem clock and reset sequencer.
// Assumes a single 25 MHz system clock; all other clocks are modelled or sampled.
// Function
// - Power-on reset shared with fabric, from platform_manager.
// - Internal PLL makes 1.2 GHz core clock.
// - PLL reference selectable: platform_manager or fabric.
// - Some clocks are integer divisions of core.
// - User clocks 62.5-500 MHz; never 500 fabric-side.
// - User and coherent clocks treated mutually asynchronous.
// - Every reset input handled as asynchronous; reset_n_in here acts only at clk_in edges.
// - Power-on reset feeds only central controller logic.
// - No internal clock toggles before power-on release.
// - Sub-block reset registers come up holding reset.
// - No interconnect access while system reset asserted.
// - Software writes registers; sub-blocks released individually.
// - Each PCIe port has own fundamental reset.
// - Fundamental reset output is buffered input copy.

package ccr_pkg;

    // ************************************************************
    // Clocking figures
    // ************************************************************
    localparam int unsigned SYS_CLOCK_HZ      = 25_000_000;
    localparam int unsigned CORE_CLOCK_MHZ    = 1200;
    localparam int unsigned PLL_LOCK_TIME_NS  = 1000;
    localparam int unsigned PLL_LOCK_CYCLES   =
        (PLL_LOCK_TIME_NS * (SYS_CLOCK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned CORE_DIV_DEFAULT  = 4;
    localparam int unsigned USER_CLK_MIN_KHZ  = 62_500;
    localparam int unsigned USER_CLK_MAX_KHZ  = 500_000;
    localparam int unsigned COHERENT_MIN_MHZ  = 100;
    localparam int unsigned COHERENT_MAX_MHZ  = 391;

    // ************************************************************
    // Sub-block resets
    // ************************************************************
    localparam int unsigned NUM_SUBBLOCKS     = 8;
    localparam logic [7:0]  SUBBLOCK_RST_INIT = 8'hFF;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic {
        CCR_REF_PLATFORM,
        CCR_REF_FABRIC
    } ccr_ref_e;

    // User clock settings: 62.5, 125, 250 and 500 MHz.
    typedef enum logic [1:0] {
        CCR_USER_62M5,
        CCR_USER_125M,
        CCR_USER_250M,
        CCR_USER_500M
    } ccr_user_e;

    typedef enum logic [1:0] {
        CCR_POR_HELD,
        CCR_PLL_LOCKING,
        CCR_CLOCKS_RUN
    } ccr_state_e;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] data;
    } ccr_ic_req_s;

    typedef struct packed {
        logic       ack;
        logic       refused;
        logic [7:0] data;
    } ccr_ic_rsp_s;

endpackage

/* File: testbench.sv */
// Self-checking bench of the clock and reset sequencer.
// Assumes the checker is bound here and the fabric model sits beside.
`timescale 1ns/1ps
module testbench;
    import ccr_pkg::*;
    // ****
    // Stimulus and checks
    // ****
    logic        clk_in = 1'b0;
    logic        reset_n_in, por_n_in, sys_rst, fr0, fr1, fb0, fb1, fab_run;
    logic        f0, f1, locked, core, cdiv, u0, u1;
    logic [1:0]  seen;
    logic [7:0]  sub;
    ccr_ref_e    ref_sel, ref_out;
    ccr_user_e   user_set;
    ccr_ic_req_s req;
    ccr_ic_rsp_s rsp, rq;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          hp[4] = '{8, 4, 2, 2};

    always #20 clk_in = !clk_in;

    ccr_fabric_model u_fab (.run_in(fab_run), .coh0_clock_out(f0), .coh1_clock_out(f1));
    ccr_clock_reset #(.CORE_DIV(4)) dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .por_n_in(por_n_in),
        .system_reset_in(sys_rst), .pll_ref_select_in(ref_sel),
        .user_clock_setting_in(user_set), .fabric_coherent_port0_clock(f0),
        .fabric_coherent_port1_clock(f1), .pcie_port0_fund_reset_in(fr0),
        .pcie_port1_fund_reset_in(fr1), .ic_req_in(req), .ic_rsp_out(rsp),
        .pll_locked_out(locked), .pll_ref_out(ref_out), .core_clock_out(core),
        .core_div_clock_out(cdiv), .pcie_port0_user_clock(u0),
        .pcie_port1_user_clock(u1), .coherent_clock_seen_out(seen),
        .subblock_reset_out(sub), .pcie_port0_fund_reset_buf(fb0),
        .pcie_port1_fund_reset_buf(fb1));

    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic ic(input logic wr, input logic [7:0] d);
        @(negedge clk_in);
        req = '{valid: 1'b1, write: wr, data: d};
        // The answer stands for one cycle only, so it is taken before the next edge.
        @(negedge clk_in);
        rq = rsp;
        req = '0;
    endtask

    function automatic logic pick(input int sel);
        return (sel == 0) ? u0 : (sel == 1) ? u1 : cdiv;
    endfunction

    // Power-on reset drops off the clock edge; no request is in flight then.
    task automatic t_power(input ccr_ref_e r);
        @(negedge clk_in);
        por_n_in = 1'b0;
        ref_sel = r;
        #1 chk("sub held", 8'hFF, sub);
        @(negedge clk_in);
        chk("core idle", 8'h00, {7'h00, core});
        chk("lock idle", 8'h00, {7'h00, locked});
        por_n_in = 1'b1;
        for (int i = 0; i < 60 && locked !== 1'b1; i++) @(negedge clk_in);
        chk("locked", 8'h01, {7'h00, locked});
        chk("ref", {7'h00, r}, {7'h00, ref_out});
        chk("sub after lock", 8'hFF, sub);
    endtask

    task automatic t_coh();
        chk("seen idle", 8'h00, {6'h00, seen});
        fab_run = 1'b1;
        repeat (20) @(negedge clk_in);
        chk("seen run", 8'h03, {6'h00, seen});
    endtask

    task automatic t_refuse();
        sys_rst = 1'b1;
        repeat (3) @(negedge clk_in);
        ic(1'b1, 8'h00);
        chk("refused", 8'h02, {6'h00, rq.refused, rq.ack});
        @(posedge clk_in);
        #1 chk("sub kept", 8'hFF, sub);
        @(negedge clk_in);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk_in);
    endtask

    task automatic t_write();
        logic [7:0] v[3] = '{8'h5A, 8'hA5, 8'h00};
        foreach (v[i]) begin
            ic(1'b1, v[i]);
            chk("wr ack", 8'h01, {7'h00, rq.ack});
            @(posedge clk_in);
            #1 chk("sub", v[i], sub);
            ic(1'b0, 8'h00);
            chk("rd data", v[i], rq.data);
        end
    endtask

    task automatic t_fund();
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_in);
            {fr1, fr0} = i[1:0];
            #1 chk("fund buf", {6'h00, i[1:0]}, {6'h00, fb1, fb0});
        end
    endtask

    task automatic meas(input int sel, input int exp);
        int  n;
        logic v;
        repeat (3) begin
            v = pick(sel);
            n = 0;
            while (pick(sel) === v && n < 40) begin
                @(negedge clk_in);
                n++;
            end
        end
        chk("half period", exp[7:0], n[7:0]);
    endtask

    task automatic t_clocks();
        for (int s = 0; s < 4; s++) begin
            user_set = ccr_user_e'(s);
            meas(0, hp[s]);
            meas(1, hp[s]);
        end
        meas(2, 4);
    endtask

    initial begin
        {reset_n_in, por_n_in, sys_rst, fr0, fr1, fab_run} = '0;
        ref_sel = CCR_REF_PLATFORM;
        user_set = CCR_USER_62M5;
        req = '0;
        repeat (16) @(negedge clk_in);
        reset_n_in = 1'b1;
        t_power(CCR_REF_FABRIC);
        t_coh();
        t_refuse();
        t_write();
        t_fund();
        t_clocks();
        t_power(CCR_REF_PLATFORM);
        final_report();
    end

    initial begin
        #(5000 * 40);
        n_errors++;
        final_report();
    end
endmodule

bind ccr_clock_reset ccr_checker u_chk (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .por_n_in(por_n_in),
    .system_reset_in(system_reset_in), .ic_req_in(ic_req_in), .ic_rsp_out(ic_rsp_out),
    .pcie_port0_fund_reset_in(pcie_port0_fund_reset_in),
    .pcie_port1_fund_reset_in(pcie_port1_fund_reset_in),
    .pll_locked_out(pll_locked_out), .core_clock_out(core_clock_out),
    .subblock_reset_out(subblock_reset_out),
    .pcie_port0_fund_reset_buf(pcie_port0_fund_reset_buf),
    .pcie_port1_fund_reset_buf(pcie_port1_fund_reset_buf));
